// file: core/sar_adc_control.v
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_control_map.vh"

module sar_adc_control (
  input  wire        I_CLK_SYS,
  input  wire        I_RST,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [9:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output wire        O_PREADY,
  output wire        O_PSLVERR,
  input  wire        I_STANDBY,
  input  wire        I_COMP,
  output reg         O_SAMPLE,
  output reg  [9:0]  O_DAC_CODE,
  output wire        O_LADDER_ON,
  output wire [3:0]  O_CHANNEL,
  output wire        O_AIN_DISABLE,
  output reg         O_CONV_DONE_IRQ
);

  // ****************************************************************
  // Local definitions
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CONV = 2'b01;

  function [10:0] conv_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h0:    conv_cycles = `CONV_CYC_000;
        3'h2:    conv_cycles = `CONV_CYC_010;
        3'h3:    conv_cycles = `CONV_CYC_011;
        3'h4:    conv_cycles = `CONV_CYC_100;
        3'h5:    conv_cycles = `CONV_CYC_101;
        3'h6:    conv_cycles = `CONV_CYC_110;
        default: conv_cycles = `CONV_CYC_RESERVED;
      endcase
    end
  endfunction

  function reg_hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg        start_bit;
  reg [1:0]  mode;
  reg        ain_disable;
  reg [3:0]  channel_select;
  reg [5:0]  timing;
  reg [9:0]  result;
  reg        eoc;
  reg        busy;
  reg [1:0]  state;
  reg [10:0] elapsed;
  reg [10:0] total;
  reg [10:0] step;
  reg [10:0] slot_cnt;
  reg [3:0]  slot;
  reg [9:0]  sar;
  reg        comp_meta;
  reg        comp_sync;
  reg        next_eoc;
  reg [1:0]  next_state;
  reg        next_busy;
  reg [7:0]  read_mux;

  wire apb_setup  = I_PSEL & ~I_PENABLE;
  wire apb_access = I_PSEL & I_PENABLE;
  wire hit_ctrl   = reg_hit(I_PADDR, `IDX_CONV_CTRL);
  wire hit_timing = reg_hit(I_PADDR, `IDX_CONV_TIMING);
  wire hit_status = reg_hit(I_PADDR, `IDX_RESULT_LOW_STAT);
  wire hit_high   = reg_hit(I_PADDR, `IDX_RESULT_HIGH);
  wire mapped     = hit_ctrl | hit_timing | hit_status | hit_high;
  wire wr_en      = apb_access & I_PWRITE & mapped & ~I_STANDBY;
  wire rd_high    = apb_access & ~I_PWRITE & hit_high;

  wire mode_run   = (mode == `MODE_SINGLE) || (mode == `MODE_REPEAT);
  wire start_go   = (state == ST_IDLE) & start_bit & mode_run;
  wire abort      = (state == ST_CONV) & ~mode_run;
  wire slot_end   = (state == ST_CONV) & (slot <= `SAR_LAST_SLOT) & (slot_cnt == step - 11'd1);
  wire conv_end   = (state == ST_CONV) & ~abort & (elapsed == total - 11'd1);
  wire [9:0] next_trial = `SAR_MSB_CODE >> slot;
  wire [9:0] decided    = comp_sync ? O_DAC_CODE : sar;
  wire [10:0] load_total = conv_cycles(timing[`TIM_CODE_HI:`TIM_CODE_LO]);

  assign O_PREADY      = 1'b1;
  assign O_PSLVERR     = apb_access & ~mapped;
  assign O_CHANNEL     = channel_select;
  assign O_AIN_DISABLE = ain_disable;
  assign O_LADDER_ON   = timing[`TIM_LADDER_BIT] | busy;

  // ****************************************************************
  // Comparator synchroniser
  // ****************************************************************
  always @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= I_COMP;
      comp_sync <= comp_meta;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Standby wins over any write in the same cycle
  always @(posedge I_CLK_SYS) begin
    if (I_RST || I_STANDBY) begin
      {start_bit, mode, ain_disable, channel_select} <= `RST_CONV_CTRL;
    end else begin
      if (wr_en && hit_ctrl) begin
        mode           <= I_PWDATA[`CTRL_MODE_HI:`CTRL_MODE_LO];
        ain_disable    <= I_PWDATA[`CTRL_AIN_DIS_BIT];
        channel_select <= I_PWDATA[`CTRL_CHAN_HI:0];
        start_bit      <= I_PWDATA[`CTRL_START_BIT];
      end else if (start_go || !mode_run) begin
        start_bit <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Timing register
  // ****************************************************************
  always @(posedge I_CLK_SYS) begin
    if (I_RST || I_STANDBY) begin
      timing <= `RST_CONV_TIMING;
    end else if (wr_en && hit_timing) begin
      timing <= I_PWDATA[`TIM_FIELD_HI:0];
    end
  end

  // ****************************************************************
  // End flag
  // ****************************************************************
  // Completion in the cycle of a clearing read or start keeps the flag set
  always @* begin
    next_eoc = eoc;
    if (rd_high || start_go) begin
      next_eoc = 1'b0;
    end
    if (conv_end) begin
      next_eoc = 1'b1;
    end
  end

  // ****************************************************************
  // Conversion state
  // ****************************************************************
  always @* begin
    next_state = state;
    next_busy  = busy;
    case (state)
      ST_IDLE: begin
        if (start_go) begin
          next_state = ST_CONV;
          next_busy  = 1'b1;
        end
      end
      ST_CONV: begin
        if (abort) begin
          next_state = ST_IDLE;
          next_busy  = 1'b0;
        end else if (conv_end && (mode != `MODE_REPEAT)) begin
          next_state = ST_IDLE;
          next_busy  = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  always @(posedge I_CLK_SYS) begin
    if (I_RST || I_STANDBY) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      busy  <= next_busy;
    end
  end

  // ****************************************************************
  // Conversion timer
  // ****************************************************************
  // Slot length rounds down, so all slots end before the total time
  always @(posedge I_CLK_SYS) begin
    if (I_RST || I_STANDBY) begin
      elapsed <= 11'd0;
      total   <= `CONV_CYC_000;
      step    <= 11'd1;
    end else if (start_go) begin
      elapsed <= 11'd0;
      total   <= load_total;
      step    <= load_total / `CONV_SLOTS;
    end else if (conv_end) begin
      elapsed <= 11'd0;
    end else if (state == ST_CONV) begin
      elapsed <= elapsed + 11'd1;
    end
  end

  // ****************************************************************
  // Result and completion pulse
  // ****************************************************************
  // Result moves only on completion or reset/standby, so an abort leaves it untouched
  always @(posedge I_CLK_SYS) begin
    if (I_RST || I_STANDBY) begin
      result          <= `RST_RESULT;
      eoc             <= 1'b0;
      O_CONV_DONE_IRQ <= 1'b0;
    end else begin
      eoc             <= next_eoc;
      O_CONV_DONE_IRQ <= conv_end;
      if (conv_end) begin
        result <= sar;
      end
    end
  end

  // ****************************************************************
  // Approximation slots
  // ****************************************************************
  always @(posedge I_CLK_SYS) begin
    if (I_RST || I_STANDBY) begin
      slot_cnt   <= 11'd0;
      slot       <= 4'd0;
      sar        <= 10'h000;
      O_SAMPLE   <= 1'b0;
      O_DAC_CODE <= 10'h000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_go) begin
            slot_cnt   <= 11'd0;
            slot       <= 4'd0;
            sar        <= 10'h000;
            O_SAMPLE   <= 1'b1;
            O_DAC_CODE <= 10'h000;
          end
        end
        ST_CONV: begin
          if (abort) begin
            O_SAMPLE   <= 1'b0;
            O_DAC_CODE <= 10'h000;
          end else if (conv_end) begin
            if (mode == `MODE_REPEAT) begin
              slot_cnt   <= 11'd0;
              slot       <= 4'd0;
              sar        <= 10'h000;
              O_SAMPLE   <= 1'b1;
              O_DAC_CODE <= 10'h000;
            end else begin
              O_DAC_CODE <= 10'h000;
            end
          end else if (slot_end) begin
            slot_cnt <= 11'd0;
            slot     <= slot + 4'd1;
            if (slot == 4'd0) begin
              O_SAMPLE   <= 1'b0;
              O_DAC_CODE <= `SAR_MSB_CODE;
            end else begin
              sar <= decided;
              if (slot < `SAR_LAST_SLOT) begin
                O_DAC_CODE <= decided | next_trial;
              end else begin
                O_DAC_CODE <= decided;
              end
            end
          end else begin
            slot_cnt <= slot_cnt + 11'd1;
          end
        end
        default: begin
          O_SAMPLE   <= 1'b0;
          O_DAC_CODE <= 10'h000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Captured in the setup phase so read data come from a register
  always @* begin
    read_mux = 8'h00;
    if (hit_ctrl) begin
      read_mux = {start_bit, mode, ain_disable, channel_select};
    end else if (hit_timing) begin
      read_mux = {2'b00, timing};
    end else if (hit_status) begin
      read_mux = {result[1:0], eoc, busy, 4'h0};
    end else if (hit_high) begin
      read_mux = result[9:2];
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (apb_setup && !I_PWRITE) begin
      O_PRDATA <= {24'h00_0000, read_mux};
    end
  end

endmodule // sar_adc_control

`default_nettype wire

// file: core/sar_adc_control_map.vh
`ifndef SAR_ADC_CONTROL_MAP_VH
`define SAR_ADC_CONTROL_MAP_VH

// ****************************************************************
// Register indices (byte address = index * 4)
// ****************************************************************
`define IDX_CONV_CTRL       8'h1c
`define IDX_CONV_TIMING     8'h1d
`define IDX_RESULT_LOW_STAT 8'h1e
`define IDX_RESULT_HIGH     8'h1f

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CONV_CTRL       8'h10
`define RST_CONV_TIMING     6'h00
`define RST_RESULT          10'h000

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_START_BIT      7
`define CTRL_MODE_HI        6
`define CTRL_MODE_LO        5
`define CTRL_AIN_DIS_BIT    4
`define CTRL_CHAN_HI        3
`define TIM_LADDER_BIT      5
`define TIM_CODE_HI         3
`define TIM_CODE_LO         1
`define TIM_FIELD_HI        5
`define STAT_EOC_BIT        5
`define STAT_BUSY_BIT       4

// ****************************************************************
// Operating modes
// ****************************************************************
`define MODE_DISABLED       2'h0
`define MODE_SINGLE         2'h1
`define MODE_RESERVED       2'h2
`define MODE_REPEAT         2'h3

// ****************************************************************
// Conversion times in I_CLK_SYS clock periods
// ****************************************************************
`define CONV_CYC_000        11'd39
`define CONV_CYC_010        11'd78
`define CONV_CYC_011        11'd156
`define CONV_CYC_100        11'd312
`define CONV_CYC_101        11'd624
`define CONV_CYC_110        11'd1248
`define CONV_CYC_RESERVED   11'd1248
`define CONV_SLOTS          11'd11
`define SAR_MSB_CODE        10'h200
`define SAR_LAST_SLOT       4'd10

`endif

// file: verification/sar_adc_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_asserts (
  input wire        I_CLK_SYS,
  input wire        I_RST,
  input wire        I_PSEL,
  input wire        I_PENABLE,
  input wire        I_PWRITE,
  input wire [9:0]  I_PADDR,
  input wire [31:0] I_PWDATA,
  input wire        O_PSLVERR,
  input wire        I_STANDBY,
  input wire        O_SAMPLE,
  input wire        O_LADDER_ON,
  input wire [3:0]  O_CHANNEL,
  input wire        O_AIN_DISABLE,
  input wire        O_CONV_DONE_IRQ
);
  // ******
  // Checks
  // ******
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  wire acc    = I_PSEL && I_PENABLE;
  wire wr_ctl = acc && I_PWRITE && I_PADDR == 10'h070 && !I_STANDBY;
  // Ladder low proves the sequencer idle; sampling shows one edge after the write lands
  AST_START: assert property (wr_ctl && I_PWDATA[7] && I_PWDATA[5] && !O_LADDER_ON |-> ##2 O_SAMPLE)
    else $error("start did not launch sampling");
  AST_FIELDS: assert property (wr_ctl |=> O_CHANNEL == $past(I_PWDATA[3:0]) && O_AIN_DISABLE == $past(I_PWDATA[4]))
    else $error("control fields not applied");
  AST_IRQ_PULSE: assert property (O_CONV_DONE_IRQ |=> !O_CONV_DONE_IRQ)
    else $error("completion pulse too long");
  AST_STANDBY: assert property (I_STANDBY |=> !O_SAMPLE && !O_CONV_DONE_IRQ && O_AIN_DISABLE && O_CHANNEL == 4'h0)
    else $error("standby did not initialise");
  AST_ABORT: assert property (wr_ctl && !I_PWDATA[5] |=> ##1 (!O_SAMPLE && !O_CONV_DONE_IRQ) [*2])
    else $error("disable did not stop conversion");
  AST_LADDER: assert property (O_SAMPLE |-> O_LADDER_ON)
    else $error("ladder off while sampling");
  AST_MIN_TIME: assert property ($rose(O_SAMPLE) |-> ##2 !O_CONV_DONE_IRQ [*8])
    else $error("conversion ended too early");
  AST_UNMAPPED: assert property (acc && (I_PADDR[9:4] != 6'h07 || I_PADDR[1:0] != 2'h0) |-> O_PSLVERR)
    else $error("unmapped access not flagged");
  cover property (O_CONV_DONE_IRQ);
  cover property (wr_ctl && !I_PWDATA[5] && O_LADDER_ON);
  cover property (I_STANDBY && O_LADDER_ON);
endmodule // sar_adc_control_asserts
`default_nettype wire

// file: verification/adc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
  input  wire logic       i_sample,
  input  wire logic [9:0] i_dac_code,
  input  wire logic [9:0] i_level,
  output logic            o_comp
);
  logic [9:0] held = 10'h000;
  // Hold tracks the input only while sampling, so late changes are missed
  always_latch begin
    if (i_sample) begin
      held <= i_level;
    end
  end
  assign o_comp = held >= i_dac_code;
endmodule // adc_analog_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst, psel, pen, pwr, stby, irq, smp, lad, aind, err, rdy, comp, se;
  logic [9:0]  paddr, dac, lvl;
  logic [31:0] pwd, prd;
  logic [3:0]  ch;
  logic [7:0]  q;
  int          bad_count, total_checks, k, n;
  localparam logic [9:0]  CTL = 10'h070, TIM = 10'h074, STA = 10'h078, RHI = 10'h07c;
  localparam logic [10:0] CYC [7] = '{11'd39, 11'd78, 11'd156, 11'd312, 11'd624, 11'd1248, 11'd1248};
  localparam logic [2:0]  TC [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [9:0]  LV [7] = '{10'h000, 10'h3ff, 10'h2a5, 10'h15a, 10'h200, 10'h1ff, 10'h0a5};
  sar_adc_control dut (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err), .I_STANDBY(stby),
    .I_COMP(comp), .O_SAMPLE(smp), .O_DAC_CODE(dac), .O_LADDER_ON(lad), .O_CHANNEL(ch),
    .O_AIN_DISABLE(aind), .O_CONV_DONE_IRQ(irq));
  adc_analog_model sh (.i_sample(smp), .i_dac_code(dac), .i_level(lvl), .o_comp(comp));
  // *************
  // Bus and checks
  // *************
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = prd[7:0];
    se = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chkf(input string s, input logic c);
    chk(s, 8'h01, {7'h0, c});
  endtask
  // Bounded wait so a dead sequencer ends in a mismatch, not a hang
  task automatic wirq();
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (irq !== 1'b1 && k < 3000);
    chkf("irq", irq === 1'b1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    {rst, psel, pen, pwr, stby} = 5'h10;
    paddr = 10'h000;
    pwd = 32'h0;
    lvl = 10'h000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(0, CTL, 8'h00);
    chk("ctl reset", 8'h10, q);
    apb(0, STA, 8'h00);
    chk("status reset", 8'h00, q & 8'hf0);
    apb(0, 10'h040, 8'h00);
    chkf("unmapped", se === 1'b1 && q === 8'h00);
    $display("reset test done");
    apb(1, CTL, 8'hc3);
    repeat (3) @(posedge clk);
    apb(0, CTL, 8'h00);
    chk("reserved mode", 8'h43, q);
    chkf("reserved idle", smp === 1'b0 && lad === 1'b0);
    for (int i = 0; i < 7; i++) begin
      lvl = LV[i];
      apb(1, TIM, {4'h1, TC[i], 1'b0});
      apb(1, CTL, 8'ha3);
      wirq();
      chkf("conv time", k >= CYC[i] && k <= CYC[i] + 2);
      apb(0, CTL, 8'h00);
      chk("ctl", 8'h23, q);
      chkf("pins", ch === 4'h3 && aind === 1'b0 && lad === 1'b0);
      apb(0, STA, 8'h00);
      chk("status", {LV[i][1:0], 6'h20}, q & 8'hf0);
      apb(0, RHI, 8'h00);
      chk("result", LV[i][9:2], q);
      apb(0, STA, 8'h00);
      chkf("end flag clear", q[5] === 1'b0);
    end
    $display("single test done");
    apb(1, TIM, 8'h30);
    apb(0, TIM, 8'h00);
    chkf("ladder on", lad === 1'b1 && q === 8'h30);
    lvl = 10'h0f0;
    apb(1, CTL, 8'ha3);
    wirq();
    lvl = 10'h30c;
    apb(1, CTL, 8'ha3);
    apb(0, STA, 8'h00);
    chk("old status", 8'h10, q & 8'hf0);
    apb(0, RHI, 8'h00);
    chk("old result", 8'h3c, q);
    wirq();
    apb(0, RHI, 8'h00);
    chk("new result", 8'hc3, q);
    $display("reread test done");
    apb(1, CTL, 8'he5);
    wirq();
    wirq();
    lvl = 10'h155;
    chkf("repeat period", k >= 39 && k <= 41);
    repeat (10) @(posedge clk);
    apb(1, CTL, 8'h05);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      n += (irq === 1'b1);
    end
    chkf("abort", n == 0 && smp === 1'b0);
    apb(0, RHI, 8'h00);
    chk("kept result", 8'hc3, q);
    $display("repeat test done");
    apb(1, CTL, 8'he5);
    repeat (5) @(posedge clk);
    stby <= 1'b1;
    apb(1, CTL, 8'h0f);
    apb(0, CTL, 8'h00);
    chk("ctl standby", 8'h10, q);
    apb(0, STA, 8'h00);
    chk("status standby", 8'h00, q & 8'hf0);
    chkf("pins standby", ch === 4'h0 && aind === 1'b1 && lad === 1'b0);
    stby <= 1'b0;
    $display("standby test done");
    give_verdict();
  end
endmodule // tb
bind sar_adc_control sar_adc_control_asserts chk_u (.I_CLK_SYS, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE,
  .I_PADDR, .I_PWDATA, .O_PSLVERR, .I_STANDBY, .O_SAMPLE, .O_LADDER_ON, .O_CHANNEL, .O_AIN_DISABLE,
  .O_CONV_DONE_IRQ);
`default_nettype wire
